// ---- dsp_pkg.sv ----
// Shared constants and types of the dual serial port block.
package dsp_pkg;

  // ********************************************************************
  // Sizes and rates
  // ********************************************************************
  localparam int NCH = 2;
  localparam int AW = 8;
  localparam int DW = 21;
  localparam int QD = 16;
  localparam int QAW = 4;
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_MIN = 35;
  localparam int BAUD_MAX_232 = 115_200;
  localparam int BAUD_MAX_485 = 2_304_000;
  localparam logic [DW-1:0] DIV_MIN_232 =
    DW'((CLK_HZ + BAUD_MAX_232 - 1) / BAUD_MAX_232);
  localparam logic [DW-1:0] DIV_MIN_485 =
    DW'((CLK_HZ + BAUD_MAX_485 - 1) / BAUD_MAX_485);
  localparam logic [DW-1:0] DIV_MAX = DW'(CLK_HZ / BAUD_MIN);

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [4:0] OFF_CFG = 5'h00;
  localparam logic [4:0] OFF_DIV = 5'h04;
  localparam logic [4:0] OFF_DIR = 5'h08;
  localparam logic [4:0] OFF_TXQ = 5'h0C;
  localparam logic [4:0] OFF_RXQ = 5'h10;
  localparam logic [4:0] OFF_STAT = 5'h14;
  localparam logic [AW-1:0] OFF_GLOBAL = 8'h40;
  localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h40;
  localparam logic [AW-1:0] OFF_IRQ_EN = 8'h44;
  localparam logic [AW-1:0] OFF_IRQ_CLR = 8'h48;
  localparam logic [AW-1:0] OFF_HWRST = 8'h4C;

  // ********************************************************************
  // Fields, codes and reset values
  // ********************************************************************
  localparam int CFG_PAR = 0;
  localparam int CFG_LEN = 2;
  localparam int CFG_STOP = 4;
  localparam int CFG_PROTO = 5;
  localparam logic [7:0] CFG_RST = 8'h6C;
  localparam logic [DW-1:0] DIV_RST = DIV_MIN_232;
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PR_RTS = 2'h1;
  localparam logic [1:0] PR_XON = 2'h2;
  localparam logic [1:0] PR_485 = 2'h3;
  localparam logic [1:0] DIR_RX = 2'h0;
  localparam logic [1:0] DIR_TX = 2'h1;
  localparam logic [1:0] DIR_ECHO = 2'h2;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [31:0] RX_EMPTY_VAL = 32'hFFFFFFFF;
  localparam int EV_RX = 0;
  localparam int EV_TXDONE = 1;
  localparam int EV_OVF = 2;
  localparam int EV_ERR = 3;
  localparam int EV_W = 4;
  localparam int EVN = NCH * EV_W;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b011,
    ST_PAR = 3'b010,
    ST_STOP = 3'b110
  } dsp_st_t;

endpackage

// ---- dsp_rem.sv ----
// Remote serial station on one line.
`timescale 1ns/1ps

module dsp_rem (
  input wire logic pclk, // Clock
  input wire logic txd,  // Line from the block
  output logic rxd       // Line to the block
);
  int bitc = 22;
  int nb = 8;
  logic [1:0] par = 2'h0;
  logic [9:0] got[$];
  int t0[$];
  int i;
  logic [7:0] v;
  logic p;
  initial rxd = 1'h1;
  // Receiver samples mid bit with the block's own framing.
  always begin
    @(negedge txd);
    t0.push_back(int'($time));
    v = 8'h00;
    p = 1'h0;
    repeat (bitc / 2) @(posedge pclk);
    for (i = 0; i < nb; i++) begin
      repeat (bitc) @(posedge pclk);
      v[i] = txd;
    end
    if (par != 2'h0) begin
      repeat (bitc) @(posedge pclk);
      p = txd;
    end
    repeat (bitc) @(posedge pclk);
    got.push_back({txd, p, v});
  end
  task automatic send(input logic [7:0] d);
    int k;
    rxd <= 1'h0;
    repeat (bitc) @(posedge pclk);
    for (k = 0; k < nb; k++) begin
      rxd <= d[k];
      repeat (bitc) @(posedge pclk);
    end
    rxd <= 1'h1;
    repeat (bitc) @(posedge pclk);
  endtask
endmodule

// ---- dsp_tick.sv ----
// Half-bit tick divider for one serial direction.
`timescale 1ns/1ps

module dsp_tick (
  input wire logic pclk,    // System clock
  input wire logic presetn, // Asynchronous reset, active low
  dsp_tick_if.div tk        // Run, period and tick
);
  typedef struct packed {
    logic [19:0] cnt;
  } dsp_tick_st_t;

  dsp_tick_st_t s;
  dsp_tick_st_t next_s;

  // The counter restarts with every frame so ticks align to its start.
  assign tk.tick = tk.run && (s.cnt == tk.half - 20'h00001);

  always_comb begin
    next_s = s;
    if (!tk.run || tk.tick) begin
      next_s.cnt = '0;
    end else begin
      next_s.cnt = s.cnt + 20'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ---- dsp_tick_if.sv ----
// Link between a frame engine and its half-bit tick divider.
`timescale 1ns/1ps

interface dsp_tick_if;
  logic run;
  logic [19:0] half;
  logic tick;
  modport src (output run, output half, input tick);
  modport div (input run, input half, output tick);
endinterface

// ---- dsp_top.sv ----
// Dual serial port with queues, APB registers and interrupt.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps

module dsp_top (
  input wire logic pclk,                       // APB clock
  input wire logic presetn,                    // Reset, active low
  input wire logic psel,                       // APB select
  input wire logic penable,                    // APB access phase
  input wire logic pwrite,                     // APB write
  input wire logic [dsp_pkg::AW-1:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,              // APB write data
  output logic [31:0] prdata,                  // APB read data
  output logic pready,                         // APB ready
  output logic pslverr,                        // APB unmapped address
  input wire logic [dsp_pkg::NCH-1:0] rxd,     // Serial receive lines
  input wire logic [dsp_pkg::NCH-1:0] cts_n,   // Clear to send, low
  output logic [dsp_pkg::NCH-1:0] txd,         // Serial send lines
  output logic [dsp_pkg::NCH-1:0] de,          // Line driver enable
  output logic [dsp_pkg::NCH-1:0] rts_n,       // Ready to receive, low
  output logic irq                             // Interrupt level
);
  import dsp_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [NCH-1:0][7:0] cfg;
    logic [NCH-1:0][DW-1:0] div;
    logic [NCH-1:0][1:0] dir;
    logic [NCH-1:0][QD-1:0][7:0] txm;
    logic [NCH-1:0][QAW:0] twp;
    logic [NCH-1:0][QAW:0] trp;
    logic [NCH-1:0] twres;
    logic [NCH-1:0][QD-1:0][7:0] rxm;
    logic [NCH-1:0][QAW:0] rwp;
    logic [NCH-1:0][QAW:0] rrp;
    dsp_st_t [NCH-1:0] tst;
    logic [NCH-1:0][1:0] thb;
    logic [NCH-1:0][2:0] tbit;
    logic [NCH-1:0][7:0] tsh;
    logic [NCH-1:0] tpar;
    dsp_st_t [NCH-1:0] rxs;
    logic [NCH-1:0] rhb;
    logic [NCH-1:0][2:0] rbit;
    logic [NCH-1:0][7:0] rsh;
    logic [NCH-1:0] rpar;
    logic [NCH-1:0] txd;
    logic [NCH-1:0] de;
    logic [NCH-1:0] rts_n;
    logic [NCH-1:0] xoff;
    logic [EVN-1:0] ist;
    logic [EVN-1:0] ien;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dsp_top_st_t;

  dsp_top_st_t s;
  dsp_top_st_t next_s;
  logic [NCH-1:0][DW-1:0] effd;
  logic [NCH-1:0] tick_tx;
  logic [NCH-1:0] tick_rx;

  // Clamp the programmed divisor to the limits of the selected protocol.
  // Kept apart from the next-state logic so the tick path forms no loop.
  always_comb begin
    logic [DW-1:0] lo;
    lo = '0;
    effd = '0;
    for (int c = 0; c < NCH; c++) begin
      lo = (s.cfg[c][CFG_PROTO +: 2] == PR_485) ?
           DIV_MIN_485 : DIV_MIN_232;
      effd[c] = (s.div[c] < lo) ? lo :
                (s.div[c] > DIV_MAX) ? DIV_MAX : s.div[c];
    end
  end

  // ********************************************************************
  // Bit-rate dividers
  // ********************************************************************
  dsp_tick_if tk_tx[NCH] ();
  dsp_tick_if tk_rx[NCH] ();

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign tk_tx[g].run = (s.tst[g] != ST_IDLE);
    assign tk_tx[g].half = effd[g][DW-1:1];
    assign tick_tx[g] = tk_tx[g].tick;
    assign tk_rx[g].run = (s.rxs[g] != ST_IDLE);
    assign tk_rx[g].half = effd[g][DW-1:1];
    assign tick_rx[g] = tk_rx[g].tick;
    dsp_tick u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .tk(tk_tx[g])
    );
    dsp_tick u_rx (
      .pclk(pclk),
      .presetn(presetn),
      .tk(tk_rx[g])
    );
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    logic [1:0] par;
    logic [1:0] len;
    logic [1:0] pro;
    logic [1:0] dr;
    logic [2:0] last;
    logic [2:0] halves;
    logic pinit;
    logic tx_ok;
    logic line;
    logic keep;
    logic done;
    logic rerr;
    logic ch;
    logic hit;
    logic acc;
    logic hw;
    logic [QAW:0] tcnt;
    logic [QAW:0] rcnt;
    logic [7:0] rdat;
    logic [EVN-1:0] ev;
    logic [EVN-1:0] clr;
    par = '0;
    len = '0;
    pro = '0;
    dr = '0;
    last = '0;
    halves = '0;
    pinit = 1'b0;
    tx_ok = 1'b0;
    line = 1'b1;
    keep = 1'b0;
    done = 1'b0;
    rerr = 1'b0;
    ch = 1'b0;
    hit = 1'b0;
    acc = 1'b0;
    hw = 1'b0;
    tcnt = '0;
    rcnt = '0;
    rdat = '0;
    ev = '0;
    clr = '0;
    next_s = s;

    for (int c = 0; c < NCH; c++) begin
      par = s.cfg[c][CFG_PAR +: 2];
      len = s.cfg[c][CFG_LEN +: 2];
      pro = s.cfg[c][CFG_PROTO +: 2];
      dr = s.dir[c];
      last = 3'(len) + 3'h4;
      halves = !s.cfg[c][CFG_STOP] ? 3'h2 :
               (len == 2'h0) ? 3'h3 : 3'h4;
      pinit = (par == PAR_ODD);
      tcnt = s.twp[c] - s.trp[c];
      rcnt = s.rwp[c] - s.rrp[c];
      tx_ok = (tcnt != '0) && ((pro == PR_485) ?
              (dr == DIR_TX || dr == DIR_ECHO) :
              (pro == PR_RTS) ? !cts_n[c] :
              (pro == PR_XON) ? !s.xoff[c] : 1'b1);
      keep = (pro != PR_485) || (dr == DIR_RX) || (dr == DIR_ECHO);
      line = (pro == PR_485 && dr == DIR_ECHO && s.de[c]) ?
             s.txd[c] : rxd[c];
      done = 1'b0;
      rerr = 1'b0;
      rdat = 8'(s.rsh[c] >> (2'h3 - len));

      // Transmit framing.
      case (s.tst[c])
        ST_IDLE: begin
          next_s.de[c] = (pro != PR_485);
          if (tx_ok) begin
            next_s.tsh[c] = s.txm[c][s.trp[c][QAW-1:0]];
            next_s.trp[c] = s.trp[c] + 5'h01;
            next_s.tpar[c] = pinit;
            next_s.txd[c] = 1'b0;
            next_s.de[c] = 1'b1;
            next_s.thb[c] = '0;
            next_s.tst[c] = ST_START;
          end
        end
        ST_START: begin
          if (tick_tx[c]) begin
            next_s.thb[c] = s.thb[c] + 2'h1;
            if (s.thb[c] != 2'h0) begin
              next_s.thb[c] = '0;
              next_s.tbit[c] = '0;
              next_s.txd[c] = s.tsh[c][0];
              next_s.tpar[c] = s.tpar[c] ^ s.tsh[c][0];
              next_s.tsh[c] = s.tsh[c] >> 1;
              next_s.tst[c] = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (tick_tx[c]) begin
            next_s.thb[c] = s.thb[c] + 2'h1;
            if (s.thb[c] != 2'h0) begin
              next_s.thb[c] = '0;
              if (s.tbit[c] == last) begin
                next_s.txd[c] = (par == PAR_NONE) ? 1'b1 : s.tpar[c];
                next_s.tst[c] = (par == PAR_NONE) ? ST_STOP : ST_PAR;
              end else begin
                next_s.tbit[c] = s.tbit[c] + 3'h1;
                next_s.txd[c] = s.tsh[c][0];
                next_s.tpar[c] = s.tpar[c] ^ s.tsh[c][0];
                next_s.tsh[c] = s.tsh[c] >> 1;
              end
            end
          end
        end
        ST_PAR: begin
          if (tick_tx[c]) begin
            next_s.thb[c] = s.thb[c] + 2'h1;
            if (s.thb[c] != 2'h0) begin
              next_s.thb[c] = '0;
              next_s.txd[c] = 1'b1;
              next_s.tst[c] = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick_tx[c]) begin
            next_s.thb[c] = s.thb[c] + 2'h1;
            if ({1'b0, s.thb[c]} == halves - 3'h1) begin
              next_s.thb[c] = '0;
              next_s.tst[c] = ST_IDLE;
              ev[c * EV_W + EV_TXDONE] = (tcnt == '0);
            end
          end
        end
        default: begin
          next_s.tst[c] = ST_IDLE;
          next_s.txd[c] = 1'b1;
        end
      endcase

      // Receive framing, sampling at mid bit.
      case (s.rxs[c])
        ST_IDLE: begin
          if (!line) begin
            next_s.rhb[c] = 1'b0;
            next_s.rxs[c] = ST_START;
          end
        end
        ST_START: begin
          if (tick_rx[c]) begin
            next_s.rbit[c] = '0;
            next_s.rpar[c] = pinit;
            next_s.rxs[c] = line ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick_rx[c]) begin
            next_s.rhb[c] = !s.rhb[c];
            if (s.rhb[c]) begin
              next_s.rsh[c] = {line, s.rsh[c][7:1]};
              next_s.rpar[c] = s.rpar[c] ^ line;
              next_s.rbit[c] = s.rbit[c] + 3'h1;
              if (s.rbit[c] == last) begin
                next_s.rxs[c] = (par == PAR_NONE) ? ST_STOP : ST_PAR;
              end
            end
          end
        end
        ST_PAR: begin
          if (tick_rx[c]) begin
            next_s.rhb[c] = !s.rhb[c];
            if (s.rhb[c]) begin
              next_s.rpar[c] = s.rpar[c] ^ line;
              next_s.rxs[c] = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (tick_rx[c]) begin
            next_s.rhb[c] = !s.rhb[c];
            if (s.rhb[c]) begin
              done = 1'b1;
              rerr = !line || ((par != PAR_NONE) && s.rpar[c]);
              next_s.rxs[c] = ST_IDLE;
            end
          end
        end
        default: begin
          next_s.rxs[c] = ST_IDLE;
        end
      endcase

      // Queue the character, or drop it when muted or full.
      if (done && pro == PR_XON) begin
        if (rdat == CH_XOFF) begin
          next_s.xoff[c] = 1'b1;
        end else if (rdat == CH_XON) begin
          next_s.xoff[c] = 1'b0;
        end
      end
      if (done && keep) begin
        if (rcnt != 5'(QD)) begin
          next_s.rxm[c][s.rwp[c][QAW-1:0]] = rdat;
          next_s.rwp[c] = s.rwp[c] + 5'h01;
          ev[c * EV_W + EV_RX] = 1'b1;
          ev[c * EV_W + EV_ERR] = rerr;
        end else begin
          ev[c * EV_W + EV_OVF] = 1'b1;
        end
      end
      next_s.rts_n[c] = (pro == PR_RTS) && (rcnt == 5'(QD));
    end

    // ******************************************************************
    // APB slave, one wait state
    // ******************************************************************
    acc = psel && penable && !s.pready;
    next_s.pready = acc;
    next_s.pslverr = 1'b0;
    if (acc) begin
      next_s.prdata = '0;
      hit = 1'b1;
      ch = paddr[5];
      tcnt = s.twp[ch] - s.trp[ch];
      rcnt = s.rwp[ch] - s.rrp[ch];
      if (paddr < OFF_GLOBAL) begin
        case (paddr[4:0])
          OFF_CFG: begin
            next_s.prdata = {24'h000000, s.cfg[ch]};
            if (pwrite) begin
              next_s.cfg[ch] = {1'b0, pwdata[6:0]};
            end
          end
          OFF_DIV: begin
            next_s.prdata = {11'h000, s.div[ch]};
            if (pwrite) begin
              next_s.div[ch] = pwdata[DW-1:0];
            end
          end
          OFF_DIR: begin
            next_s.prdata = {30'h00000000, s.dir[ch]};
            if (pwrite) begin
              next_s.dir[ch] = pwdata[1:0];
            end
          end
          OFF_TXQ: begin
            next_s.prdata = {31'h00000000, s.twres[ch]};
            if (pwrite) begin
              next_s.twres[ch] = (tcnt == 5'(QD));
              if (tcnt != 5'(QD)) begin
                next_s.txm[ch][s.twp[ch][QAW-1:0]] = pwdata[7:0];
                next_s.twp[ch] = s.twp[ch] + 5'h01;
              end
            end
          end
          OFF_RXQ: begin
            if (!pwrite) begin
              next_s.prdata = (rcnt == '0) ? RX_EMPTY_VAL :
                {24'h000000, s.rxm[ch][s.rrp[ch][QAW-1:0]]};
              if (rcnt != '0) begin
                next_s.rrp[ch] = s.rrp[ch] + 5'h01;
              end
            end
          end
          OFF_STAT: begin
            next_s.prdata = {11'h000, tcnt, 3'h0, rcnt, 5'h00,
              (rcnt == '0), (tcnt == 5'(QD)),
              (tcnt != '0) || (s.tst[ch] != ST_IDLE)};
          end
          default: begin
            hit = 1'b0;
          end
        endcase
      end else begin
        case (paddr)
          OFF_IRQ_STAT: begin
            next_s.prdata = {24'h000000, s.ist};
          end
          OFF_IRQ_EN: begin
            next_s.prdata = {24'h000000, s.ien};
            if (pwrite) begin
              next_s.ien = pwdata[EVN-1:0];
            end
          end
          OFF_IRQ_CLR: begin
            clr = pwrite ? pwdata[EVN-1:0] : '0;
          end
          OFF_HWRST: begin
            hw = pwrite;
          end
          default: begin
            hit = 1'b0;
          end
        endcase
      end
      next_s.pslverr = !hit;
    end

    // ******************************************************************
    // Interrupt: a new event beats a clear in the same cycle
    // ******************************************************************
    next_s.ist = (s.ist & ~clr) | ev;
    next_s.irq = |(next_s.ist & next_s.ien);

    if (hw) begin
      next_s.cfg = {NCH{CFG_RST}};
      next_s.div = {NCH{DIV_RST}};
      next_s.dir = {NCH{DIR_RST}};
      next_s.twp = '0;
      next_s.trp = '0;
      next_s.rwp = '0;
      next_s.rrp = '0;
      next_s.twres = '0;
      for (int c = 0; c < NCH; c++) begin
        next_s.tst[c] = ST_IDLE;
        next_s.rxs[c] = ST_IDLE;
      end
      next_s.txd = '1;
      next_s.de = '0;
      next_s.xoff = '0;
    end
  end

  // ********************************************************************
  // Registers and outputs
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.cfg <= {NCH{CFG_RST}};
      s.div <= {NCH{DIV_RST}};
      s.dir <= {NCH{DIR_RST}};
      s.txd <= '1;
      s.rts_n <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign txd = s.txd;
  assign de = s.de;
  assign rts_n = s.rts_n;
  assign irq = s.irq;
endmodule

// ---- dsp_top_assertions.sv ----
// Port-level assertions for the dual serial port.
`timescale 1ns/1ps

module dsp_top_assertions (
  input wire logic pclk,                    // Clock
  input wire logic presetn,                 // Reset, active low
  input wire logic psel,                    // APB select
  input wire logic penable,                 // APB access phase
  input wire logic pwrite,                  // APB write
  input wire logic [dsp_pkg::AW-1:0] paddr, // APB address
  input wire logic [31:0] pwdata,           // APB write data
  input wire logic [31:0] prdata,           // APB read data
  input wire logic pready,                  // APB ready
  input wire logic pslverr,                 // APB error
  input wire logic [dsp_pkg::NCH-1:0] rxd,  // Receive lines
  input wire logic [dsp_pkg::NCH-1:0] cts_n, // Clear to send
  input wire logic [dsp_pkg::NCH-1:0] txd,  // Send lines
  input wire logic [dsp_pkg::NCH-1:0] de,   // Driver enables
  input wire logic [dsp_pkg::NCH-1:0] rts_n, // Ready to receive
  input wire logic irq                      // Interrupt
);
  import dsp_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_start;
    $fell(txd[0]);
  endsequence
  sequence s_low8;
    (!txd[0]) [*8];
  endsequence
  AST_ONE_WAIT: assert property (s_acc |=> pready)
    else $error("no ready after access");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  AST_START_LOW: assert property (s_start |-> s_low8)
    else $error("start bit too short");
  AST_DE_HOLD: assert property (s_start |-> de[0] [*8])
    else $error("start bit not driven");
  AST_START1: assert property ($fell(txd[1]) |-> (!txd[1] && de[1]) [*8])
    else $error("channel two start bad");
  AST_IDLE_HIGH: assert property (&(txd | de))
    else $error("undriven line not high");
endmodule

bind dsp_top dsp_top_assertions dsp_top_assertions_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .txd(txd), .de(de),
  .rts_n(rts_n), .irq(irq));

// ---- dsp_top_tb.sv ----
// Self-checking bench for the dual serial port.
`timescale 1ns/1ps

module dsp_top_tb;
  import dsp_pkg::*;
  localparam int BITC = 22;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [AW-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, irq, re;
  wire [NCH-1:0] rxd;
  logic [NCH-1:0] txd, de, rts_n;
  logic [NCH-1:0] cts_n = 2'h3;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  dsp_top dsp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .cts_n(cts_n), .txd(txd), .de(de), .rts_n(rts_n), .irq(irq));
  dsp_rem dsp_rem_inst_0 (.pclk(pclk), .txd(txd[0]), .rxd(rxd[0]));
  dsp_rem dsp_rem_inst_1 (.pclk(pclk), .txd(txd[1]), .rxd(rxd[1]));

  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  // ********
  // Helpers
  // ********
  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n == 20) chk("pready", 32'h1, 32'h0);
    rv = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rv & m);
  endtask
  task automatic setup(input int c, input logic [7:0] cf, input logic [1:0] dr);
    wr({3'(c), OFF_CFG}, {24'h0, cf});
    wr({3'(c), OFF_DIV}, 32'(BITC));
    wr({3'(c), OFF_DIR}, {30'h0, dr});
  endtask
  task automatic wgot(input int c, input int n);
    int k;
    for (k = 0; k < 4000; k++) begin
      if ((c ? dsp_rem_inst_1.got.size() : dsp_rem_inst_0.got.size()) >= n)
        break;
      @(posedge pclk);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    @(negedge pclk);
    chk("line", 32'h3, {30'h0, txd});
    chk("de", 32'h0, {30'h0, de});
    rd("cfg", 8'h20, 32'hFF, 32'h6C);
    rd("div", 8'h04, 32'h1FFFFF, {11'h0, DIV_RST});
    rd("rxq", 8'h10, 32'hFFFFFFFF, RX_EMPTY_VAL);
    apb(1'h0, 8'h18, 32'h0);
    chk("err", 32'h1, {31'h0, re});
  endtask
  task automatic t_dir();
    setup(0, CFG_RST, DIR_RX);
    wr(8'h0C, 32'hA5);
    repeat (100) @(posedge pclk);
    @(negedge pclk);
    chk("de", 32'h0, {30'h0, de});
    rd("held", 8'h14, 32'h1, 32'h1);
    wr(8'h08, {30'h0, DIR_TX});
    wgot(0, 1);
    chk("tx", 32'h2A5, {22'h0, dsp_rem_inst_0.got[0]});
    rd("busy", 8'h14, 32'h1, 32'h1);
    repeat (30) @(posedge pclk);
    rd("idle", 8'h14, 32'h1, 32'h0);
    chk("ch1", 32'h0, dsp_rem_inst_1.got.size());
  endtask
  task automatic t_frames();
    int n, pa, st, k, i, bits;
    logic [7:0] dm;
    logic pb;
    logic [31:0] e, g;
    for (k = 0; k < 4; k++) begin
      n = 5 + k;
      pa = k % 3;
      st = (k != 2);
      setup(1, 8'(96 + st * 16 + k * 4 + pa), DIR_TX);
      dsp_rem_inst_1.nb = n;
      dsp_rem_inst_1.par = 2'(pa);
      dsp_rem_inst_1.got.delete();
      dsp_rem_inst_1.t0.delete();
      wr(8'h2C, 32'h5A);
      wr(8'h2C, 32'hC3);
      wgot(1, 2);
      for (i = 0; i < 2; i++) begin
        dm = (i ? 8'hC3 : 8'h5A) & 8'((1 << n) - 1);
        pb = (pa == 0) ? 1'h0 : (pa == 1) ? ^dm : ~^dm;
        e = {22'h0, 1'h1, pb, dm};
        chk("frame", e, {22'h0, dsp_rem_inst_1.got[i]});
      end
      bits = 1 + n + (pa != 0);
      // The next start bit follows one clock after the last stop half.
      e = 32'((bits * 2 + (st ? (n == 5 ? 3 : 4) : 2)) * (BITC / 2) * 20
        + 20);
      g = 32'(dsp_rem_inst_1.t0[1] - dsp_rem_inst_1.t0[0]);
      chk("length", e, g);
      repeat (60) @(posedge pclk);
    end
  endtask
  task automatic t_rx();
    wr(8'h08, 32'h0);
    wr(8'h44, 32'h1);
    dsp_rem_inst_0.send(8'h3C);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h44, 32'h0);
    settle();
    chk("mask", 32'h0, {31'h0, irq});
    rd("stat", 8'h40, 32'h1, 32'h1);
    wr(8'h48, 32'h1);
    rd("clr", 8'h40, 32'h1, 32'h0);
    rd("rx", 8'h10, 32'hFFFFFFFF, 32'h3C);
    rd("empty", 8'h10, 32'hFFFFFFFF, RX_EMPTY_VAL);
    wr(8'h08, 32'h3);
    dsp_rem_inst_0.send(8'h77);
    settle();
    rd("mute", 8'h10, 32'hFFFFFFFF, RX_EMPTY_VAL);
    wr(8'h08, {30'h0, DIR_ECHO});
    dsp_rem_inst_0.got.delete();
    wr(8'h0C, 32'h96);
    wgot(0, 1);
    repeat (30) @(posedge pclk);
    rd("echo", 8'h10, 32'hFFFFFFFF, 32'h96);
  endtask
  task automatic t_full();
    int k;
    wr(8'h08, 32'h0);
    for (k = 0; k < 17; k++) begin
      wr(8'h0C, 32'(k));
      if (k == 15) rd("room", 8'h0C, 32'h1, 32'h0);
    end
    rd("full", 8'h0C, 32'h1, 32'h1);
    rd("count", 8'h14, 32'h1F0000, 32'h100000);
    wr(8'h4C, 32'h0);
    rd("cfg0", 8'h00, 32'hFF, 32'h6C);
    rd("cfg1", 8'h20, 32'hFF, 32'h6C);
    rd("flush", 8'h14, 32'h1, 32'h0);
  endtask

  task automatic t_rts();
    wr(8'h20, 32'h2C);
    wr(8'h2C, 32'h55);
    repeat (40) @(posedge pclk);
    @(negedge pclk);
    chk("hold", 32'h3, {30'h0, de[1], txd[1]});
    chk("rts", 32'h0, {31'h0, rts_n[1]});
    rd("wait", 8'h34, 32'h1, 32'h1);
    cts_n <= 2'h1;
    settle();
    chk("go", 32'h2, {30'h0, de[1], txd[1]});
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_dir();
    t_frames();
    t_rx();
    t_rts();
    t_full();
    stop_test();
  end
endmodule
